// *** rtl/rsb_pkg.sv ***
// Constants and types for the reset and standby bus sequencer.
// Functional notes
// - Reset in any state: ports become inputs.
// - Reset: strobes high, data bus released.
// - Reset in third state holds address.
// - Two-state second state acts like third.
// - Reset pin sampled on clock falling edge.
// - Early-state reset drives address low later.
package rsb_pkg;

    // ------------------------------------------------------------
    // Widths and reset values
    // ------------------------------------------------------------
    localparam int ADDR_W = 20;
    localparam int DATA_W = 8;
    localparam int PORT_W = 8;
    localparam logic PIN_IDLE = 1'b1;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 25;
    localparam int RST_LEAD_CYC_I = 10;
    localparam int RECOVERY_NS = 100;
    localparam int RECOVERY_CYC_I = (RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 4;
    localparam logic [CNT_W-1:0] RST_LEAD_CYC = CNT_W'(RST_LEAD_CYC_I);
    localparam logic [CNT_W-1:0] RECOVERY_CYC = CNT_W'(RECOVERY_CYC_I);
    localparam logic [CNT_W-1:0] CNT_MAX = 4'hf;

    // ------------------------------------------------------------
    // Access states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_FIRST,
        ST_SECOND,
        ST_THIRD
    } rsb_state_t;

endpackage

// *** rtl/rsb_sync.sv ***
// Three-stage falling-edge pin synchroniser with agreement filter.
`timescale 1ns/1ps
module rsb_sync
    import rsb_pkg::*;
#(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Pins
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] level_out
);

    logic [W-1:0] s1_q, s2_q, s3_q, lvl_q, lvl_d;

    // Only the third and second stages decide; the first feeds the second alone.
    always_comb begin
        lvl_d = lvl_q;
        for (int i = 0; i < W; i++) begin
            if (s2_q[i] == s3_q[i]) begin
                lvl_d[i] = s3_q[i];
            end
        end
    end

    always_ff @(negedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s1_q <= {W{PIN_IDLE}};
            s2_q <= {W{PIN_IDLE}};
            s3_q <= {W{PIN_IDLE}};
            lvl_q <= {W{PIN_IDLE}};
        end else begin
            s1_q <= pin_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            lvl_q <= lvl_d;
        end
    end

    assign level_out = lvl_q;

    a_sync_agree: assert property (@(negedge clk) disable iff (!arst_n)
        (s2_q == s3_q) |=> (lvl_q == $past(s3_q)))
        else $error("synchroniser level did not follow agreed stages");

endmodule

// *** rtl/rsb_top.sv ***
// External bus sequencer reacting to the reset and standby pins.
`timescale 1ns/1ps
module rsb_top
    import rsb_pkg::*;
#(
    parameter int AW = ADDR_W,
    parameter int DW = DATA_W,
    parameter int PW = PORT_W
) (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Control pins
    input wire logic external_reset_low,
    input wire logic standby_request_low,
    input wire logic onchip_ram_enable,
    // Access request
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic req_two_state,
    input wire logic [AW-1:0] req_addr,
    input wire logic [DW-1:0] req_wdata,
    output logic acc_done,
    output logic [DW-1:0] acc_rdata,
    // General port
    input wire logic [PW-1:0] port_dir,
    input wire logic [PW-1:0] port_wdata,
    output logic [PW-1:0] port_out,
    output logic [PW-1:0] port_oe_n,
    // External bus
    output logic [AW-1:0] addr_out,
    output logic addr_oe_n,
    output logic address_strobe_low,
    output logic read_strobe_low,
    output logic write_strobe_low,
    output logic strobe_oe_n,
    input wire logic [DW-1:0] data_in,
    output logic [DW-1:0] data_out,
    output logic data_oe_n,
    // Standby status
    output logic standby_active,
    output logic ram_retained,
    output logic recovery_ok
);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] pin_lvl;

    rsb_sync #(.W(2)) u_sync (
        .clk(clk),
        .arst_n(arst_n),
        .pin_in({standby_request_low, external_reset_low}),
        .level_out(pin_lvl)
    );

    logic rst_low, sby_low;
    assign rst_low = ~pin_lvl[0];
    assign sby_low = ~pin_lvl[1];

    // ------------------------------------------------------------
    // Access state machine
    // ------------------------------------------------------------
    rsb_state_t st_q, st_d;
    logic ph_q, ph_d, two_q, two_d, we_q, we_d, done_q, done_d;
    logic as_q, as_d, rd_q, rd_d, wr_q, wr_d, soe_q, soe_d, doe_q, doe_d, aoe_q, aoe_d;
    logic [AW-1:0] addr_q, addr_d;
    logic [DW-1:0] dout_q, dout_d, rdata_q, rdata_d;
    logic [PW-1:0] pout_q, pout_d, poe_q, poe_d;
    logic final_st;

    // The last state is the third, or the second of a two-state access.
    assign final_st = (st_q == ST_THIRD) || (st_q == ST_SECOND && two_q);

    always_comb begin
        st_d = st_q;
        ph_d = ph_q;
        two_d = two_q;
        we_d = we_q;
        done_d = 1'b0;
        as_d = as_q;
        rd_d = rd_q;
        wr_d = wr_q;
        soe_d = 1'b0;
        aoe_d = 1'b0;
        doe_d = doe_q;
        addr_d = addr_q;
        dout_d = dout_q;
        rdata_d = rdata_q;
        pout_d = port_wdata;
        poe_d = ~port_dir;
        if (sby_low) begin
            // Standby floats every pin and abandons any access.
            st_d = ST_IDLE;
            ph_d = 1'b0;
            as_d = 1'b1;
            rd_d = 1'b1;
            wr_d = 1'b1;
            soe_d = 1'b1;
            aoe_d = 1'b1;
            doe_d = 1'b1;
            poe_d = {PW{1'b1}};
        end else if (rst_low) begin
            poe_d = {PW{1'b1}};
            as_d = 1'b1;
            rd_d = 1'b1;
            wr_d = 1'b1;
            doe_d = 1'b1;
            if (st_q == ST_IDLE) begin
                addr_d = '0;
            end else if (final_st && !ph_q) begin
                ph_d = 1'b1;
            end else begin
                st_d = ST_IDLE;
                ph_d = 1'b0;
            end
        end else begin
            ph_d = ~ph_q;
            case (st_q)
                ST_IDLE: begin
                    ph_d = 1'b0;
                    if (req_valid) begin
                        st_d = ST_FIRST;
                        addr_d = req_addr;
                        two_d = req_two_state;
                        we_d = req_write;
                        dout_d = req_wdata;
                    end
                end
                ST_FIRST: begin
                    if (!ph_q) begin
                        as_d = 1'b0;
                        rd_d = we_q;
                        doe_d = ~we_q;
                    end else begin
                        wr_d = ~we_q;
                        st_d = ST_SECOND;
                    end
                end
                ST_SECOND, ST_THIRD: begin
                    if (ph_q && final_st) begin
                        rdata_d = we_q ? rdata_q : data_in;
                        done_d = 1'b1;
                        as_d = 1'b1;
                        rd_d = 1'b1;
                        wr_d = 1'b1;
                        doe_d = 1'b1;
                        st_d = ST_IDLE;
                    end else if (ph_q) begin
                        st_d = ST_THIRD;
                    end
                end
                default: begin
                    st_d = ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_q <= ST_IDLE;
            ph_q <= 1'b0;
            two_q <= 1'b0;
            we_q <= 1'b0;
            done_q <= 1'b0;
            as_q <= 1'b1;
            rd_q <= 1'b1;
            wr_q <= 1'b1;
            soe_q <= 1'b0;
            aoe_q <= 1'b0;
            doe_q <= 1'b1;
            addr_q <= '0;
            dout_q <= '0;
            rdata_q <= '0;
            pout_q <= '0;
            poe_q <= {PW{1'b1}};
        end else begin
            st_q <= st_d;
            ph_q <= ph_d;
            two_q <= two_d;
            we_q <= we_d;
            done_q <= done_d;
            as_q <= as_d;
            rd_q <= rd_d;
            wr_q <= wr_d;
            soe_q <= soe_d;
            aoe_q <= aoe_d;
            doe_q <= doe_d;
            addr_q <= addr_d;
            dout_q <= dout_d;
            rdata_q <= rdata_d;
            pout_q <= pout_d;
            poe_q <= poe_d;
        end
    end

    // ------------------------------------------------------------
    // Standby entry and recovery tracking
    // ------------------------------------------------------------
    logic [CNT_W-1:0] rcnt_q, rcnt_d;
    logic sby_q, sby_d, keep_q, keep_d, rec_q, rec_d;

    always_comb begin
        rcnt_d = rst_low ? ((rcnt_q == CNT_MAX) ? rcnt_q : rcnt_q + 1'b1) : '0;
        sby_d = sby_low;
        keep_d = keep_q;
        rec_d = rec_q;
        if (sby_low && !sby_q) begin
            keep_d = !onchip_ram_enable || (rcnt_q >= RST_LEAD_CYC);
            rec_d = 1'b0;
        end
        if (!sby_low && sby_q) begin
            rec_d = rst_low && (rcnt_q >= RECOVERY_CYC);
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rcnt_q <= '0;
            sby_q <= 1'b0;
            keep_q <= 1'b0;
            rec_q <= 1'b0;
        end else begin
            rcnt_q <= rcnt_d;
            sby_q <= sby_d;
            keep_q <= keep_d;
            rec_q <= rec_d;
        end
    end

    assign acc_done = done_q;
    assign acc_rdata = rdata_q;
    assign port_out = pout_q;
    assign port_oe_n = poe_q;
    assign addr_out = addr_q;
    assign addr_oe_n = aoe_q;
    assign address_strobe_low = as_q;
    assign read_strobe_low = rd_q;
    assign write_strobe_low = wr_q;
    assign strobe_oe_n = soe_q;
    assign data_out = dout_q;
    assign data_oe_n = doe_q;
    assign standby_active = sby_q;
    assign ram_retained = keep_q;
    assign recovery_ok = rec_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    a_ports_input: assert property (rst_low |=> (&port_oe_n))
        else $error("ports not switched to input on reset");
    a_strobes_high: assert property (rst_low |=>
        (address_strobe_low && read_strobe_low && write_strobe_low))
        else $error("strobes not inactive on reset");
    a_data_float: assert property (rst_low |=> data_oe_n)
        else $error("data bus still driven on reset");
    a_addr_hold: assert property ((rst_low && st_q == ST_THIRD && !ph_q)
        |=> (addr_out == $past(addr_q)))
        else $error("address not held in third state");
    a_two_state_hold: assert property ((rst_low && st_q == ST_SECOND && two_q && !ph_q)
        |=> (addr_out == $past(addr_q)) ##1 (st_q == ST_IDLE || !rst_low))
        else $error("two-state second state not treated as final");
    a_addr_low: assert property ((rst_low && !sby_low && (st_q == ST_FIRST ||
        (st_q == ST_SECOND && !two_q))) ##1 (rst_low && !sby_low)
        |=> (addr_out == '0))
        else $error("address not driven low after early reset");
    a_ram_lead: assert property ((sby_low && !sby_q && onchip_ram_enable &&
        rcnt_q < RST_LEAD_CYC) |=> !ram_retained)
        else $error("retention flagged without reset lead");
    a_ram_free: assert property ((sby_low && !sby_q && !onchip_ram_enable)
        |=> ram_retained)
        else $error("retention lost with RAM disabled");
    a_recover_res: assert property ((!sby_low && sby_q && !rst_low)
        |=> !recovery_ok)
        else $error("recovery accepted without reset");

    c_read_done: cover property (acc_done && !we_q);
    c_reset_third: cover property (rst_low && st_q == ST_THIRD);
    c_standby_keep: cover property (standby_active && ram_retained);
    c_recovery: cover property ($rose(recovery_ok));

endmodule

// *** tb/rsb_far_model.sv ***
// External memory and reset/standby controller facing the sequencer.
`timescale 1ns/1ps
module rsb_far_model
    import rsb_pkg::*;
(
    // Clock
    input wire logic clk,
    // External bus
    input wire logic [ADDR_W-1:0] addr_out,
    input wire logic read_strobe_low,
    input wire logic write_strobe_low,
    input wire logic [DATA_W-1:0] data_out,
    input wire logic data_oe_n,
    output logic [DATA_W-1:0] data_in,
    // Control pins
    output logic external_reset_low,
    output logic standby_request_low
);
    logic [DATA_W-1:0] mem [256];
    logic [DATA_W-1:0] last_q = 8'h00;

    initial begin
        external_reset_low = 1'b1;
        standby_request_low = 1'b1;
    end

    always @(posedge clk) begin
        if (!write_strobe_low && !data_oe_n) begin
            mem[addr_out[7:0]] <= data_out;
        end
        if (!read_strobe_low) begin
            last_q <= mem[addr_out[7:0]];
        end
    end

    // A released bus shows the inverse of its last value, never a stale copy.
    assign data_in = read_strobe_low ? ~last_q : mem[addr_out[7:0]];

    task automatic reset_pin(input logic v);
        external_reset_low <= v;
    endtask

    task automatic enter_standby(input int lead);
        if (lead > 0) begin
            external_reset_low <= 1'b0;
            repeat (lead) @(posedge clk);
        end
        standby_request_low <= 1'b0;
        external_reset_low <= 1'b1;
    endtask

    task automatic leave_standby(input int lead);
        if (lead > 0) begin
            external_reset_low <= 1'b0;
            repeat (lead) @(posedge clk);
        end
        standby_request_low <= 1'b1;
        repeat (8) @(posedge clk);
        external_reset_low <= 1'b1;
    endtask
endmodule

// *** tb/rsb_top_bench.sv ***
// Self-checking bench for the reset and standby bus sequencer.
`timescale 1ns/1ps
module rsb_top_bench
    import rsb_pkg::*;
;
    typedef struct {int cyc; logic rd; logic [DATA_W-1:0] data;} rsb_note_t;
    logic clk, arst_n, ram_en, req_valid, req_write, req_two_state;
    logic [ADDR_W-1:0] req_addr, addr_out;
    logic [DATA_W-1:0] req_wdata, acc_rdata, data_in, data_out;
    logic [PORT_W-1:0] port_dir, port_wdata, port_out, port_oe_n, dir_n;
    logic acc_done, addr_oe_n, as_n, rd_n, wr_n, strobe_oe_n, data_oe_n;
    logic rst_pin_n, sby_pin_n, standby_active, ram_retained, recovery_ok;
    rsb_note_t notes[$];
    rsb_note_t note;
    int cyc = 0;
    int error_cnt = 0;
    int cmp_count = 0;
    logic [15:0] seed = 16'h49e7;

    assign dir_n = ~port_dir;

    rsb_top u_rsb_top (.clk(clk), .arst_n(arst_n), .external_reset_low(rst_pin_n),
        .standby_request_low(sby_pin_n), .onchip_ram_enable(ram_en), .req_valid(req_valid),
        .req_write(req_write), .req_two_state(req_two_state), .req_addr(req_addr),
        .req_wdata(req_wdata), .acc_done(acc_done), .acc_rdata(acc_rdata),
        .port_dir(port_dir), .port_wdata(port_wdata), .port_out(port_out),
        .port_oe_n(port_oe_n), .addr_out(addr_out), .addr_oe_n(addr_oe_n),
        .address_strobe_low(as_n), .read_strobe_low(rd_n), .write_strobe_low(wr_n),
        .strobe_oe_n(strobe_oe_n), .data_in(data_in), .data_out(data_out),
        .data_oe_n(data_oe_n), .standby_active(standby_active),
        .ram_retained(ram_retained), .recovery_ok(recovery_ok));

    rsb_far_model u_rsb_far_model (.clk(clk), .addr_out(addr_out), .read_strobe_low(rd_n),
        .write_strobe_low(wr_n), .data_out(data_out), .data_oe_n(data_oe_n),
        .data_in(data_in), .external_reset_low(rst_pin_n), .standby_request_low(sby_pin_n));

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (exp !== got) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic results();
        $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Request held through the take edge, then the fixed access latency runs out.
    task automatic acc(input logic wr, input logic two, input logic [ADDR_W-1:0] a,
        input logic [DATA_W-1:0] d);
        rsb_note_t n;
        req_valid <= 1'b1;
        req_write <= wr;
        req_two_state <= two;
        req_addr <= a;
        req_wdata <= d;
        @(posedge clk);
        req_valid <= 1'b0;
        n.cyc = cyc + (two ? 5 : 7);
        n.rd = !wr;
        n.data = d;
        notes.push_back(n);
        repeat (two ? 5 : 7) @(posedge clk);
    endtask

    task automatic reset_case(input logic two, input int dly, input logic held);
        logic [ADDR_W-1:0] a;
        int n;
        seed = lfsr(seed);
        a = ADDR_W'(seed) | 20'h00001;
        req_valid <= 1'b1;
        req_write <= seed[0];
        req_two_state <= two;
        req_addr <= a;
        if (dly == 0) u_rsb_far_model.reset_pin(1'b0);
        @(posedge clk);
        req_valid <= 1'b0;
        if (dly > 0) begin
            repeat (dly - 1) @(posedge clk);
            u_rsb_far_model.reset_pin(1'b0);
        end
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (port_oe_n !== {PORT_W{1'b1}} && n < 12);
        check("reset latency", (dly == 0) ? 4 : 5, n);
        check("port_oe_n", {PORT_W{1'b1}}, port_oe_n);
        check("strobes", 3'h7, {as_n, rd_n, wr_n});
        check("data_oe_n", 1'b1, data_oe_n);
        if (held) check("addr held", a, addr_out);
        @(negedge clk);
        check("addr next", held ? a : 20'h00000, addr_out);
        @(posedge clk);
        u_rsb_far_model.reset_pin(1'b1);
        repeat (8) @(posedge clk);
        check("port_oe_n back", dir_n, port_oe_n);
    endtask

    task automatic standby_case(input logic ram, input int lead, input logic keep,
        input int rlead);
        int n;
        ram_en <= ram;
        u_rsb_far_model.enter_standby(lead);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (standby_active !== 1'b1 && n < 20);
        @(negedge clk);
        check("standby oe", 11'h7ff, {addr_oe_n, strobe_oe_n, data_oe_n, port_oe_n});
        check("ram_retained", keep, ram_retained);
        @(posedge clk);
        u_rsb_far_model.leave_standby(rlead);
        repeat (8) @(posedge clk);
        check("standby_active", 1'b0, standby_active);
        check("recovery_ok", rlead >= RECOVERY_CYC_I, recovery_ok);
    endtask

    always @(posedge clk) cyc <= cyc + 1;

    always @(negedge clk) begin
        if (acc_done === 1'b1) begin
            note = notes.pop_front();
            check("acc_done cycle", note.cyc, cyc);
            if (note.rd) check("acc_rdata", note.data, acc_rdata);
        end
    end

    initial begin
        clk = 1'b0;
        forever #(CLK_PERIOD_NS / 2.0) clk = ~clk;
    end

    initial begin
        #(CLK_PERIOD_NS * 4000);
        error_cnt++;
        $display("MISMATCH watchdog expected done seen timeout");
        results();
    end

    initial begin
        arst_n = 1'b0;
        ram_en = 1'b0;
        {req_valid, req_write, req_two_state} = 3'h0;
        req_addr = 20'h00000;
        req_wdata = 8'h00;
        port_dir = 8'h00;
        port_wdata = 8'h00;
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        port_dir <= seed[7:0] | 8'h01;
        port_wdata <= seed[15:8];
        repeat (8) @(posedge clk);
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            acc(1'b1, i[0], ADDR_W'(seed), seed[15:8]);
            acc(1'b0, !i[0], ADDR_W'(seed), seed[15:8]);
        end
        req_valid <= 1'b0;
        repeat (4) @(posedge clk);
        check("notes left", 0, notes.size());
        check("port_out", port_wdata, port_out);
        reset_case(1'b0, 0, 1'b0);
        reset_case(1'b1, 0, 1'b1);
        reset_case(1'b0, 2, 1'b1);
        standby_case(1'b1, RST_LEAD_CYC_I, 1'b1, RECOVERY_CYC_I);
        standby_case(1'b0, 0, 1'b1, RECOVERY_CYC_I);
        standby_case(1'b1, 0, 1'b0, 0);
        results();
    end
endmodule
